// >>> lec_edge_chan.v
// One measuring-input channel: edge qualification, capture limit and lost-edge counter.
`timescale 1ns/100ps
`default_nettype none
`include "lec_map.vh"
module lec_edge_chan (
  input wire ref_clk, // Clock.
  input wire reset, // Asynchronous reset, active high.
  input wire level, // Logical input level, inversion applied.
  input wire is_measure, // Channel is a measuring input.
  input wire job_active, // Measurement job is running.
  input wire sel_rise, // Rising edges are wanted.
  input wire sel_fall, // Falling edges are wanted.
  input wire interval_start, // Servo cycle start or new job.
  output reg [2:0] lost_edge_count, // Saturating lost-edge count.
  output reg lost_pulse // One cycle per newly lost edge.
);
  reg level_d;
  reg [1:0] captured;
  wire rise;
  wire fall;
  wire qualify;
  // Edge detect against the previous sample; inputs are synchronous already.
  assign rise = level & ~level_d;
  assign fall = ~level & level_d;
  assign qualify = is_measure & job_active & ((rise & sel_rise) | (fall & sel_fall));
  // =====================================================================
  // Capture slots and lost counter
  // A qualifying edge in the start cycle counts into the fresh interval.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      level_d <= 1'b0;
      captured <= 2'h0;
      lost_edge_count <= 3'h0;
      lost_pulse <= 1'b0;
    end else begin
      level_d <= level;
      lost_pulse <= 1'b0;
      if (interval_start) begin
        captured <= qualify ? 2'h1 : 2'h0;
        lost_edge_count <= 3'h0;
      end else if (qualify) begin
        if (captured != `LEC_CAP_MAX) begin
          captured <= captured + 2'h1;
        end else begin
          lost_pulse <= 1'b1;
          if (lost_edge_count != `LEC_CNT_MAX) begin
            lost_edge_count <= lost_edge_count + 3'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> lec_map.vh
// Register map, field positions and codes for the lost-edge counter block.
`ifndef LEC_MAP_VH
`define LEC_MAP_VH
// =====================================================================
// Sizes
`define LEC_NCH 8
`define LEC_ADDR_W 4
`define LEC_CNT_W 3
`define LEC_CNT_MAX 3'h7
`define LEC_CAP_MAX 2'h2
// =====================================================================
// Channel modes
`define LEC_MODE_DI 2'h0
`define LEC_MODE_DO 2'h1
`define LEC_MODE_MI 2'h2
`define LEC_MODE_CAM 2'h3
// =====================================================================
// Register offsets
`define LEC_REG_STATE 4'h0
`define LEC_REG_INVERT 4'h1
`define LEC_REG_MODE_LO 4'h2
`define LEC_REG_MODE_HI 4'h3
`define LEC_REG_EDGE_RISE 4'h4
`define LEC_REG_EDGE_FALL 4'h5
`define LEC_REG_SINGLE 4'h6
`define LEC_REG_JOB_ACT 4'h7
`define LEC_REG_PAIR0 4'h8
`define LEC_REG_PAIR1 4'h9
`define LEC_REG_PAIR2 4'hA
`define LEC_REG_PAIR3 4'hB
`define LEC_REG_IRQ_STAT 4'hC
`define LEC_REG_IRQ_MASK 4'hD
// =====================================================================
// Field positions inside a pair byte
`define LEC_ODD_LSB 4
`define LEC_EVEN_LSB 0
`define LEC_ZERO8 8'h00
`endif

// >>> lec_regs.v
// Software-written configuration registers of the lost-edge counter block.
`timescale 1ns/100ps
`default_nettype none
`include "lec_map.vh"
module lec_regs (
  input wire ref_clk, // Clock.
  input wire reset, // Asynchronous reset, active high.
  input wire wr_en, // Write strobe.
  input wire [3:0] addr, // Register address.
  input wire [7:0] wdata, // Write data.
  output reg [7:0] invert, // Per-channel inversion.
  output reg [15:0] mode, // Two mode bits per channel.
  output reg [7:0] edge_rise, // Rising edge selection.
  output reg [7:0] edge_fall, // Falling edge selection.
  output reg [7:0] single_mode, // One: single measurement per job.
  output reg [7:0] irq_mask // Interrupt mask.
);
  // =====================================================================
  // Write decode; unmapped writes are dropped.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      invert <= 8'h00;
      mode <= 16'h0000;
      edge_rise <= 8'h00;
      edge_fall <= 8'h00;
      single_mode <= 8'h00;
      irq_mask <= 8'h00;
    end else if (wr_en) begin
      case (addr)
        `LEC_REG_INVERT: invert <= wdata;
        `LEC_REG_MODE_LO: mode[7:0] <= wdata;
        `LEC_REG_MODE_HI: mode[15:8] <= wdata;
        `LEC_REG_EDGE_RISE: edge_rise <= wdata;
        `LEC_REG_EDGE_FALL: edge_fall <= wdata;
        `LEC_REG_SINGLE: single_mode <= wdata;
        `LEC_REG_IRQ_MASK: irq_mask <= wdata;
        default: irq_mask <= irq_mask;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> lec_top.v
// Terminal status and lost-edge counters for eight fast I/O channels.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "lec_map.vh"
// Operation
// - Each channel's status value is its logical state with the configured inversion applied.
// - For a digital or measuring input the status follows the current input level.
// - For a digital or cam output the status follows the sensed terminal level, not the command.
// - An edge is lost-counted only while a job is active and its polarity is selected.
// - At most two qualifying edges are captured per interval; further ones are lost.
// - The lost count saturates at seven, so seven means seven or more.
// - The odd channel of a pair puts its count in bits six to four of the pair byte.
// - The even channel of a pair puts its count in bits two to zero of the pair byte.
module lec_top (
  input wire ref_clk, // 50 MHz clock.
  input wire reset, // Asynchronous reset, active high.
  input wire [3:0] addr, // Register address.
  input wire [7:0] wdata, // Write data.
  input wire wr_en, // Write strobe, one cycle.
  input wire rd_en, // Read strobe, one cycle.
  output reg [7:0] rdata, // Read data, valid the cycle after rd_en.
  input wire servo_tick, // One-cycle pulse at each servo cycle start.
  input wire [7:0] job_active, // Per-channel measurement job running.
  input wire [7:0] job_start, // Per-channel pulse when a new job starts.
  input wire [7:0] fast_io_terminal, // Sensed terminal levels.
  output reg [7:0] channel_state_value, // Status per channel.
  output reg irq // Level interrupt.
);
  wire [7:0] invert;
  wire [15:0] mode;
  wire [7:0] edge_rise;
  wire [7:0] edge_fall;
  wire [7:0] single_mode;
  wire [7:0] irq_mask;
  wire [7:0] logical;
  wire [7:0] is_measure;
  wire [7:0] interval_start;
  wire [7:0] lost_pulse;
  wire [23:0] counts;
  wire [31:0] pair_bytes;
  reg [7:0] irq_stat;
  reg [7:0] next_irq_stat;
  reg [7:0] next_rdata;

  // =====================================================================
  // Configuration registers
  lec_regs u_regs (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(wr_en),
    .addr(addr),
    .wdata(wdata),
    .invert(invert),
    .mode(mode),
    .edge_rise(edge_rise),
    .edge_fall(edge_fall),
    .single_mode(single_mode),
    .irq_mask(irq_mask)
  );

  // =====================================================================
  // Per-channel logic
  // Inputs and outputs alike report the sensed terminal, never the command,
  // so a shorted driver shows as a status that differs from the command.
  genvar g;
  generate
    for (g = 0; g < `LEC_NCH; g = g + 1) begin : g_ch
      assign logical[g] = fast_io_terminal[g] ^ invert[g];
      assign is_measure[g] = (mode[2*g+1:2*g] == `LEC_MODE_MI);
      // Cyclic mode restarts on the servo tick, single mode on a new job.
      assign interval_start[g] = single_mode[g] ? job_start[g] : servo_tick;
      lec_edge_chan u_chan (
        .ref_clk(ref_clk),
        .reset(reset),
        .level(logical[g]),
        .is_measure(is_measure[g]),
        .job_active(job_active[g]),
        .sel_rise(edge_rise[g]),
        .sel_fall(edge_fall[g]),
        .interval_start(interval_start[g]),
        .lost_edge_count(counts[3*g+2:3*g]),
        .lost_pulse(lost_pulse[g])
      );
    end
    // Pack pairs: odd channel high field, even low, bits seven and three zero.
    for (g = 0; g < `LEC_NCH / 2; g = g + 1) begin : g_pair
      assign pair_bytes[8*g+7:8*g] = {1'b0, counts[6*g+5:6*g+3], 1'b0, counts[6*g+2:6*g]};
    end
  endgenerate

  // =====================================================================
  // Status output register
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      channel_state_value <= 8'h00;
    end else begin
      channel_state_value <= logical;
    end
  end

  // =====================================================================
  // Read mux; unmapped addresses read zero.
  always @* begin
    case (addr)
      `LEC_REG_STATE: next_rdata = logical;
      `LEC_REG_INVERT: next_rdata = invert;
      `LEC_REG_MODE_LO: next_rdata = mode[7:0];
      `LEC_REG_MODE_HI: next_rdata = mode[15:8];
      `LEC_REG_EDGE_RISE: next_rdata = edge_rise;
      `LEC_REG_EDGE_FALL: next_rdata = edge_fall;
      `LEC_REG_SINGLE: next_rdata = single_mode;
      `LEC_REG_JOB_ACT: next_rdata = job_active;
      `LEC_REG_PAIR0: next_rdata = pair_bytes[7:0];
      `LEC_REG_PAIR1: next_rdata = pair_bytes[15:8];
      `LEC_REG_PAIR2: next_rdata = pair_bytes[23:16];
      `LEC_REG_PAIR3: next_rdata = pair_bytes[31:24];
      `LEC_REG_IRQ_STAT: next_rdata = irq_stat;
      `LEC_REG_IRQ_MASK: next_rdata = irq_mask;
      default: next_rdata = `LEC_ZERO8;
    endcase
  end

  // =====================================================================
  // Sticky lost-edge status; clear on read, a new event in that cycle wins.
  always @* begin
    next_irq_stat = irq_stat;
    if (rd_en && addr == `LEC_REG_IRQ_STAT) begin
      next_irq_stat = 8'h00;
    end
    next_irq_stat = next_irq_stat | lost_pulse;
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
      irq_stat <= 8'h00;
      irq <= 1'b0;
    end else begin
      rdata <= rd_en ? next_rdata : `LEC_ZERO8;
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_mask);
    end
  end
endmodule
`default_nettype wire

// >>> lec_top_bench.sv
// Self-checking bench for the lost-edge counter block.
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Bench
module lec_top_bench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic servo_tick = 1'b0;
  logic [7:0] job_active = 8'h00;
  logic [7:0] job_start = 8'h00;
  logic [7:0] fast_io_terminal = 8'h00;
  logic [7:0] rdata;
  logic [7:0] channel_state_value;
  logic irq;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  lec_top u_lec_top (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .servo_tick(servo_tick),
    .job_active(job_active), .job_start(job_start), .fast_io_terminal(fast_io_terminal),
    .channel_state_value(channel_state_value), .irq(irq));
  // Clock; a hang is cut short well past the roughly 140 cycles the run needs.
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Bus tasks leave a spare cycle so no strobe is driven twice in one step.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // Software view: only one channel's field is kept, the rest masked off.
  task automatic rd_field(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk(rdata & m, exp);
  endtask
  task automatic pulse(input logic tick, input logic [7:0] start);
    @(posedge ref_clk);
    servo_tick <= tick;
    job_start <= start;
    @(posedge ref_clk);
    servo_tick <= 1'b0;
    job_start <= 8'h00;
  endtask
  task automatic toggle(input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (2) @(posedge ref_clk);
      fast_io_terminal <= fast_io_terminal ^ m;
    end
  endtask
  // Status in every mode, plus refused and unmapped accesses.
  task automatic t_state;
    rd(4'hE, 8'h00);
    wr(4'h8, 8'h55);
    rd(4'h8, 8'h00);
    wr(4'h1, 8'h0F);
    rd(4'h1, 8'h0F);
    for (int m = 0; m < 4; m++) begin
      wr(4'h2, {4{m[1:0]}});
      wr(4'h3, {4{m[1:0]}});
      fast_io_terminal <= 8'h5A ^ m[7:0];
      repeat (2) @(posedge ref_clk);
      #1 chk(channel_state_value, 8'h55 ^ m[7:0]);
      rd(4'h0, 8'h55 ^ m[7:0]);
    end
    wr(4'h1, 8'h00);
    fast_io_terminal <= 8'h00;
    wr(4'h3, 8'h00);
  endtask
  // Ten toggles: ch0 loses three rises, ch1 saturates, ch2 has no job.
  task automatic t_lost;
    wr(4'h2, 8'h2A);
    wr(4'h4, 8'h07);
    wr(4'h5, 8'h02);
    wr(4'hD, 8'h01);
    job_active <= 8'h03;
    pulse(1'b1, 8'h00);
    toggle(8'h07, 10);
    repeat (4) @(posedge ref_clk);
    #1 chk({7'h00, irq}, 8'h01);
    rd(4'h8, 8'h73);
    rd_field(4'h8, 8'h07, 8'h03);
    rd_field(4'h8, 8'h70, 8'h70);
    rd(4'h9, 8'h00);
    rd(4'h7, 8'h03);
    // Mask only the second channel, then none: the level must follow the mask.
    wr(4'hD, 8'h02);
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h00, irq}, 8'h01);
    wr(4'hD, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h00, irq}, 8'h00);
    wr(4'hD, 8'h01);
    rd(4'hD, 8'h01);
    rd(4'hC, 8'h03);
    rd(4'hC, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h00, irq}, 8'h00);
    pulse(1'b1, 8'h00);
    rd(4'h8, 8'h00);
  endtask
  // Single mode keeps its count across a servo cycle until the next job.
  task automatic t_single;
    wr(4'h6, 8'h01);
    pulse(1'b0, 8'h01);
    toggle(8'h01, 6);
    pulse(1'b1, 8'h00);
    rd(4'h8, 8'h01);
    pulse(1'b0, 8'h01);
    rd(4'h8, 8'h00);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_state();
    t_lost();
    t_single();
    complete_run();
  end
endmodule
`default_nettype wire

// >>> lec_top_sva.sv
// Port-level checker for the lost-edge counter block.
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Checker
module lec_top_chk (
  input wire logic ref_clk, // Clock.
  input wire logic reset, // Reset.
  input wire logic [3:0] addr, // Address.
  input wire logic [7:0] wdata, // Write data.
  input wire logic wr_en, // Write strobe.
  input wire logic rd_en, // Read strobe.
  input wire logic [7:0] rdata, // Read data.
  input wire logic servo_tick, // Cycle start.
  input wire logic [7:0] job_active, // Jobs.
  input wire logic [7:0] job_start, // Job starts.
  input wire logic [7:0] fast_io_terminal, // Terminals.
  input wire logic [7:0] channel_state_value, // Status.
  input wire logic irq // Interrupt.
);
  logic [2:0] up;
  logic seen_job;
  logic [7:0] inv_shadow;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Status is held at zero just after reset, so state relations wait three edges.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      up <= 3'h0;
      seen_job <= 1'b0;
      inv_shadow <= 8'h00;
    end else begin
      up <= {up[1:0], 1'b1};
      seen_job <= seen_job | (|job_active);
      // Shadow of the inversion register, rebuilt from the bus alone.
      if (wr_en && addr == 4'h1) begin
        inv_shadow <= wdata;
      end
    end
  end
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property ($past(rd_en) && $past(addr) > 4'hD |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_pair_gaps: assert property ($past(rd_en) && $past(addr[3:2]) == 2'h2
    |-> !rdata[7] && !rdata[3]) else $error("pair byte gap bits set");
  a_state_tracks: assert property (up[2] && !$past(wr_en, 2) |->
    (channel_state_value ^ $past(channel_state_value))
    == ($past(fast_io_terminal) ^ $past(fast_io_terminal, 2)))
    else $error("status change differs from terminal change");
  a_state_steady: assert property (up[2] && !$past(wr_en, 2) &&
    $past(fast_io_terminal) == $past(fast_io_terminal, 2) |-> $stable(channel_state_value))
    else $error("status moved with steady input");
  // Read data and the status output are both registered from the same sample.
  a_state_read: assert property ($past(rd_en) && $past(addr) == 4'h0
    |-> rdata == channel_state_value) else $error("status read mismatch");
  a_invert_read: assert property ($past(rd_en) && $past(addr) == 4'h1
    |-> rdata == $past(inv_shadow)) else $error("inversion readback mismatch");
  a_irq_cause: assert property ($rose(irq) && !$past(wr_en) && !$past(wr_en, 2) |->
    |{$past(job_active), $past(job_active, 2), $past(job_active, 3), $past(job_active, 4)})
    else $error("interrupt without active job");
  a_no_job_count: assert property ($past(rd_en) && $past(addr[3:2]) == 2'h2
    && !seen_job |-> rdata == 8'h00) else $error("count without any job");
  c_irq: cover property ($rose(irq));
  c_pair: cover property ($past(rd_en) && rdata == 8'h73);
  c_state: cover property (!$stable(channel_state_value));
  c_tick: cover property (servo_tick && (|job_active));
  c_job: cover property (|job_start);
endmodule
bind lec_top lec_top_chk u_chk (.ref_clk(ref_clk), .reset(reset), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .servo_tick(servo_tick),
  .job_active(job_active), .job_start(job_start), .fast_io_terminal(fast_io_terminal),
  .channel_state_value(channel_state_value), .irq(irq));
`default_nettype wire
